// ---- hw/emi_defs.vh ----
// Constants for the external memory interface block
`ifndef EMI_DEFS_VH
`define EMI_DEFS_VH
`define EMI_SFR_PAGE_SEL   8'hAA
`define EMI_SFR_PAGE_SEL_PG 8'h00
`define EMI_SFR_PTR_LOW    8'h82
`define EMI_SFR_PTR_HIGH   8'h83
`define EMI_SFR_CONFIG     8'hB2
`define EMI_SFR_CONFIG_PG  8'h0F
`define EMI_PAGE_SEL_RST   8'h00
`define EMI_CONFIG_RST     5'h03
`define EMI_CFG_MUX_BIT    4
`define EMI_CFG_MAP_HI     3
`define EMI_CFG_MAP_LO     2
`define EMI_MAP_INTERNAL   2'h0
`define EMI_MAP_SPLIT      2'h1
`define EMI_MAP_SPLIT_BANK 2'h2
`define EMI_MAP_EXTERNAL   2'h3
`define EMI_ONCHIP_TOP     16'h1000
`define EMI_VARIANT_LARGE  2'h0
`define EMI_VARIANT_MID    2'h1
`define EMI_VARIANT_SMALL  2'h2
`define EMI_ALE_CYCLES     2'h1
`define EMI_STROBE_CYCLES  2'h2
`endif

// ---- hw/emi_external_mem_port.v ----
// External data memory interface: address forming, registers and pins
//
// How it works
// R01: Pointer form uses full 16-bit pointer
// R02: Pointer bytes readable and writable separately
// R03: Index form: page high, index low
// R04: Page value N selects page N*0x100
// R05: Page select RW, reset zero, 0xAA
// R06: Claim pins only during off-chip move
// R07: Return pins to latches after move
// R08: Release drivers of pins used as inputs
// R09: Never alter pin output mode
// R10: Software parks latches idle high
// R11: Software skips read/write strobe pins
// R12: Software skips latch strobe when multiplexed
// R13: Largest variant pin map, both modes
// R14: Mid variant multiplexed pin map
// R15: Variant limits on supported modes
// R16: Software configuration order
// R17: Config bit selects mux or not
// R18: Mapping field routes on/off-chip
// R19: Latch strobe pulses during address phase
`timescale 1ns/100ps
`include "emi_defs.vh"

module emi_external_mem_port #(
    parameter [1:0] VARIANT = `EMI_VARIANT_LARGE
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [7:0]  sfrAddr,
    input  wire [7:0]  sfrPage,
    input  wire        sfrWrite,
    input  wire        sfrRead,
    input  wire [7:0]  sfrWrData,
    output reg  [7:0]  sfrRdData,
    input  wire        moveStart,
    input  wire        moveWrite,
    input  wire        moveUsePointer,
    input  wire [7:0]  moveIndex,
    input  wire [7:0]  moveWrData,
    output wire        moveBusy,
    output reg         moveDone,
    output reg         moveOnChip,
    output reg  [15:0] moveAddr,
    output reg  [7:0]  moveRdData,
    input  wire [7:0]  port1Latch,
    input  wire [7:0]  port2Latch,
    input  wire [7:0]  port3Latch,
    input  wire [7:0]  port4Latch,
    input  wire [7:0]  port3In,
    input  wire [7:0]  port4In,
    output reg  [7:0]  port1Out,
    output reg  [7:0]  port2Out,
    output reg  [7:0]  port3Out,
    output reg  [7:0]  port4Out,
    output reg  [7:0]  port1Oe,
    output reg  [7:0]  port2Oe,
    output reg  [7:0]  port3Oe,
    output reg  [7:0]  port4Oe
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_ALE    = 2'h1;
    localparam [1:0] ST_STROBE = 2'h2;
    localparam [1:0] ST_END    = 2'h3;

    reg  [7:0]  pointerLow;
    reg  [7:0]  pointerHigh;
    reg  [7:0]  pageSelect;
    reg  [4:0]  cfgBits;
    reg  [1:0]  state;
    reg  [1:0]  count;
    reg         isWrite;
    reg         nonMux;
    reg  [7:0]  dataOut;
    reg  [7:0]  p3Sync1;
    reg  [7:0]  p3Sync2;
    reg  [7:0]  p4Sync1;
    reg  [7:0]  p4Sync2;
    reg  [15:0] next_addr;
    reg         next_onChip;
    reg  [7:0]  dataIn;
    wire [1:0]  mapMode;
    wire        cfgNonMux;

    assign mapMode   = cfgBits[`EMI_CFG_MAP_HI:`EMI_CFG_MAP_LO];
    // R15: mid variant is forced multiplexed
    assign cfgNonMux = cfgBits[`EMI_CFG_MUX_BIT] &&
                       (VARIANT == `EMI_VARIANT_LARGE);
    assign moveBusy  = (state != ST_IDLE);

    // SFR writes; page select and config each decode their own page
    always @(posedge clk) begin
        if (sys_rst) begin
            pointerLow  <= 8'h00;
            pointerHigh <= 8'h00;
            pageSelect  <= `EMI_PAGE_SEL_RST;
            cfgBits     <= `EMI_CONFIG_RST;
        end else if (sfrWrite) begin
            // R02: pointer byte writes
            if (sfrAddr == `EMI_SFR_PTR_LOW)
                pointerLow <= sfrWrData;
            if (sfrAddr == `EMI_SFR_PTR_HIGH)
                pointerHigh <= sfrWrData;
            // R05: page select write
            if (sfrAddr == `EMI_SFR_PAGE_SEL &&
                sfrPage == `EMI_SFR_PAGE_SEL_PG)
                pageSelect <= sfrWrData;
            // R17: mux and mapping bits
            if (sfrAddr == `EMI_SFR_CONFIG &&
                sfrPage == `EMI_SFR_CONFIG_PG)
                cfgBits <= sfrWrData[4:0];
        end
    end

    // Read data registered; unmapped reads return zero
    always @(posedge clk) begin
        if (sys_rst) begin
            sfrRdData <= 8'h00;
        end else if (sfrRead) begin
            // R02: pointer byte reads
            if (sfrAddr == `EMI_SFR_PTR_LOW)
                sfrRdData <= pointerLow;
            else if (sfrAddr == `EMI_SFR_PTR_HIGH)
                sfrRdData <= pointerHigh;
            // R05: page select read
            else if (sfrAddr == `EMI_SFR_PAGE_SEL &&
                     sfrPage == `EMI_SFR_PAGE_SEL_PG)
                sfrRdData <= pageSelect;
            else if (sfrAddr == `EMI_SFR_CONFIG &&
                     sfrPage == `EMI_SFR_CONFIG_PG)
                sfrRdData <= {3'h0, cfgBits};
            else
                sfrRdData <= 8'h00;
        end
    end

    // Effective address and on/off-chip decision
    always @* begin
        if (moveUsePointer) begin
            // R01: full pointer as address
            next_addr = {pointerHigh, pointerLow};
        end else if (mapMode == `EMI_MAP_SPLIT) begin
            // Split without bank: high byte from parked latch
            next_addr = {port3Latch, moveIndex};
            if (VARIANT == `EMI_VARIANT_MID || cfgNonMux)
                next_addr = {port2Latch, moveIndex};
            if (next_addr < `EMI_ONCHIP_TOP)
                next_addr = {pageSelect, moveIndex};
        end else begin
            // R03: page high, index low
            // R04: page N covers N*0x100 upward
            next_addr = {pageSelect, moveIndex};
        end
        // R18: mapping mode routing
        case (mapMode)
            `EMI_MAP_INTERNAL:   next_onChip = 1'b1;
            `EMI_MAP_EXTERNAL:   next_onChip = 1'b0;
            default:             next_onChip = next_addr < `EMI_ONCHIP_TOP;
        endcase
        // R15: smallest variant has no off-chip access
        if (VARIANT == `EMI_VARIANT_SMALL)
            next_onChip = 1'b1;
    end

    // Pin inputs pass two flops before use
    always @(posedge clk) begin
        if (sys_rst) begin
            p3Sync1 <= 8'h00;
            p3Sync2 <= 8'h00;
            p4Sync1 <= 8'h00;
            p4Sync2 <= 8'h00;
        end else begin
            p3Sync1 <= port3In;
            p3Sync2 <= p3Sync1;
            p4Sync1 <= port4In;
            p4Sync2 <= p4Sync1;
        end
    end

    always @* begin
        if (VARIANT == `EMI_VARIANT_MID)
            dataIn = p3Sync2;
        else
            dataIn = p4Sync2;
    end

    // Access sequencer; on-chip accesses finish in one cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            count      <= 2'h0;
            isWrite    <= 1'b0;
            nonMux     <= 1'b0;
            dataOut    <= 8'h00;
            moveDone   <= 1'b0;
            moveOnChip <= 1'b0;
            moveAddr   <= 16'h0000;
            moveRdData <= 8'h00;
        end else begin
            moveDone <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (moveStart) begin
                        moveAddr   <= next_addr;
                        moveOnChip <= next_onChip;
                        isWrite    <= moveWrite;
                        nonMux     <= cfgNonMux;
                        dataOut    <= moveWrData;
                        if (next_onChip) begin
                            moveDone <= 1'b1;
                        end else if (cfgNonMux) begin
                            state <= ST_STROBE;
                            count <= `EMI_STROBE_CYCLES;
                        end else begin
                            state <= ST_ALE;
                            count <= `EMI_ALE_CYCLES;
                        end
                    end
                end
                ST_ALE: begin
                    if (count == 2'h1) begin
                        state <= ST_STROBE;
                        count <= `EMI_STROBE_CYCLES;
                    end else begin
                        count <= count - 2'h1;
                    end
                end
                ST_STROBE: begin
                    if (count == 2'h1) begin
                        state <= ST_END;
                    end else begin
                        count <= count - 2'h1;
                    end
                end
                ST_END: begin
                    // R07: release pins as move completes
                    state    <= ST_IDLE;
                    moveDone <= 1'b1;
                    // Sync flops lag two cycles; still strobe data
                    if (!isWrite)
                        moveRdData <= dataIn;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Pin ownership; enables only drive, mode set elsewhere
    always @* begin
        // R06: latches own pins when not in off-chip move
        // R09: only value and enable, never drive mode
        port1Out = port1Latch;
        port2Out = port2Latch;
        port3Out = port3Latch;
        port4Out = port4Latch;
        port1Oe  = 8'h00;
        port2Oe  = 8'h00;
        port3Oe  = 8'h00;
        port4Oe  = 8'h00;
        if (state == ST_ALE || state == ST_STROBE) begin
            port1Oe[7:5] = {1'b1, 1'b1, !nonMux};
            port1Out[5]  = (state == ST_ALE);
            port1Out[6]  = !(state == ST_STROBE && !isWrite);
            port1Out[7]  = !(state == ST_STROBE && isWrite);
            if (VARIANT == `EMI_VARIANT_MID) begin
                // R14: mid variant shared bus on port 3
                port2Out = moveAddr[15:8];
                port2Oe  = 8'hFF;
                // R19: low address valid during latch strobe only
                // R08: data pins released during read
                if (state == ST_ALE) begin
                    port3Out = moveAddr[7:0];
                    port3Oe  = 8'hFF;
                end else if (isWrite) begin
                    port3Out = dataOut;
                    port3Oe  = 8'hFF;
                end
            end else begin
                // R13: largest variant maps by mode
                port3Oe = 8'hFF;
                if (nonMux) begin
                    port3Out = moveAddr[7:0];
                    port2Out = moveAddr[15:8];
                    port2Oe  = 8'hFF;
                end else begin
                    port3Out = moveAddr[15:8];
                end
                // R19: low address on shared bus first
                if (state == ST_ALE) begin
                    port4Out = moveAddr[7:0];
                    port4Oe  = 8'hFF;
                end else if (isWrite) begin
                    // R08: data driven only when writing
                    port4Out = dataOut;
                    port4Oe  = 8'hFF;
                end
            end
        end
    end

endmodule

// ---- bench/emi_port_asserts.sv ----
// Checker on the memory port pins and registers
`timescale 1ns/100ps
module emi_port_asserts (
    input logic        clk,
    input logic        sys_rst,
    input logic [7:0]  sfrAddr,
    input logic [7:0]  sfrPage,
    input logic        sfrWrite,
    input logic        sfrRead,
    input logic [7:0]  sfrWrData,
    input logic [7:0]  sfrRdData,
    input logic        moveStart,
    input logic        moveBusy,
    input logic        moveDone,
    input logic [15:0] moveAddr,
    input logic [7:0]  port1Latch,
    input logic [7:0]  port4Latch,
    input logic [7:0]  port1Out,
    input logic [7:0]  port3Out,
    input logic [7:0]  port4Out,
    input logic [7:0]  port1Oe,
    input logic [7:0]  port2Oe,
    input logic [7:0]  port3Oe,
    input logic [7:0]  port4Oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire pgW = sfrWrite && sfrAddr == 8'hAA && sfrPage == 8'h00;
    wire pgR = sfrRead && sfrAddr == 8'hAA && sfrPage == 8'h00;
    idle_pins_a: assert property (
        !moveBusy |-> (port1Oe | port2Oe | port3Oe | port4Oe) == 8'h00)
        else $error("pins driven outside a move");
    idle_follow_a: assert property (
        !moveBusy |-> port1Out == port1Latch && port4Out == port4Latch)
        else $error("pins do not follow latches");
    read_float_a: assert property (
        moveBusy && !port1Out[6] |-> port4Oe == 8'h00)
        else $error("data bus driven during read");
    write_drive_a: assert property (
        moveBusy && !port1Out[7] |-> port4Oe == 8'hFF)
        else $error("data bus not driven during write");
    ale_addr_a: assert property (
        moveBusy && port1Oe[5] && port1Out[5] |->
        port4Out == moveAddr[7:0] && port3Out == moveAddr[15:8])
        else $error("address wrong during latch strobe");
    strobe_len_a: assert property (
        $fell(port1Out[6]) && moveBusy |=> !port1Out[6] ##1 port1Out[6])
        else $error("read strobe width wrong");
    move_done_a: assert property (
        moveStart && !moveBusy |-> ##[1:6] moveDone)
        else $error("move never completes");
    done_pulse_a: assert property (
        moveDone |=> !moveDone)
        else $error("done longer than one cycle");
    page_rw_a: assert property (
        pgW ##1 pgR |=> sfrRdData == $past(sfrWrData, 2))
        else $error("page select readback wrong");
    cover property (moveBusy && port1Oe[5] && port1Out[5]);
    cover property (moveBusy && !port1Out[7]);
    cover property (moveBusy && !port1Out[6] && !port1Oe[5]);
endmodule

// ---- bench/emi_xram_model.sv ----
// Off-chip memory model on the port pins
`timescale 1ns/100ps
module emi_xram_model (
    input  logic        clk,
    input  logic        nonMux,
    input  logic [7:0]  port1Out,
    input  logic [7:0]  port2Out,
    input  logic [7:0]  port3Out,
    input  logic [7:0]  port4Out,
    output logic [7:0]  port4In,
    output logic [15:0] lastAddr,
    output logic [7:0]  lastWrData
);
    logic [7:0] lastOut = 8'h00;
    wire rdLow = !port1Out[6];
    wire [15:0] pinAddr = nonMux ? {port2Out, port3Out} : lastAddr;
    // Contents are a fixed function of the address
    wire [7:0] memData = pinAddr[15:8] ^ pinAddr[7:0];
    // Released bus shows inverse, never stale data
    assign port4In = rdLow ? memData : ~lastOut;
    initial lastAddr = 16'h0000;
    initial lastWrData = 8'h00;
    always @(posedge clk) begin
        if (port1Out[5] && !nonMux)
            lastAddr <= {port3Out, port4Out};
        if (nonMux && (rdLow || !port1Out[7]))
            lastAddr <= pinAddr;
        if (rdLow)
            lastOut <= memData;
        if (!port1Out[7])
            lastWrData <= port4Out;
    end
endmodule

// ---- bench/external_memory_interface_tb_top.sv ----
// Directed bench for the external memory port
`timescale 1ns/100ps
module external_memory_interface_tb_top;
    logic        clk = 1'b0, sys_rst = 1'b1, nonMux = 1'b0;
    logic        sfrWrite = 1'b0, sfrRead = 1'b0, moveStart = 1'b0;
    logic        moveWrite = 1'b0, moveUsePointer = 1'b0;
    logic [7:0]  sfrAddr = 8'h00, sfrPage = 8'h00, sfrWrData = 8'h00;
    logic [7:0]  moveIndex = 8'h00, moveWrData = 8'h00, port4In;
    logic [7:0]  sfrRdData, moveRdData, lastWrData;
    logic [7:0]  port1Out, port2Out, port3Out, port4Out;
    logic [7:0]  port1Oe, port2Oe, port3Oe, port4Oe;
    logic [15:0] moveAddr, lastAddr;
    logic        moveBusy, moveDone, moveOnChip;
    int          miscompares = 0, checks = 0;
    // latches parked idle, latch strobe low
    emi_external_mem_port u_dut (.port1Latch(8'hDF), .port2Latch(8'hFF),
        .port3Latch(8'hFF), .port4Latch(8'hFF), .port3In(8'h00), .*);
    emi_xram_model u_mem (.*);
    initial forever #10 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic sfr_wr(input logic [7:0] a, p, d);
        // Gap edge so back-to-back writes never touch the strobe twice
        @(posedge clk);
        sfrAddr <= a;
        sfrPage <= p;
        sfrWrData <= d;
        sfrWrite <= 1'b1;
        @(posedge clk);
        sfrWrite <= 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, p, output logic [7:0] d);
        sfrAddr <= a;
        sfrPage <= p;
        sfrRead <= 1'b1;
        @(posedge clk);
        sfrRead <= 1'b0;
        @(posedge clk);
        d = sfrRdData;
    endtask
    task automatic do_move(input logic w, ptr, input logic [7:0] idx, wd);
        moveWrite <= w;
        moveUsePointer <= ptr;
        moveIndex <= idx;
        moveWrData <= wd;
        moveStart <= 1'b1;
        @(posedge clk);
        moveStart <= 1'b0;
        repeat (20) begin
            #1;
            if (moveDone === 1'b1) break;
            @(posedge clk);
        end
        check(moveDone, 1'b1);
        @(posedge clk);
    endtask
    task automatic t_regs;
        logic [7:0] v;
        sfr_rd(8'hAA, 8'h00, v);
        check(v, 8'h00);
        sfr_rd(8'hB2, 8'h0F, v);
        check(v, 8'h03);
        sfr_wr(8'hAA, 8'h00, 8'hFF);
        sfr_rd(8'hAA, 8'h00, v);
        check(v, 8'hFF);
        sfr_wr(8'h83, 8'h00, 8'h12);
        sfr_wr(8'h82, 8'h00, 8'h34);
        sfr_rd(8'h83, 8'h00, v);
        check(v, 8'h12);
        sfr_rd(8'h82, 8'h00, v);
        check(v, 8'h34);
        sfr_rd(8'hAB, 8'h00, v);
        check(v, 8'h00);
    endtask
    task automatic t_onchip;
        do_move(1'b0, 1'b1, 8'h00, 8'h00);
        check(moveAddr, 16'h1234);
        check(moveOnChip, 1'b1);
        do_move(1'b0, 1'b0, 8'hFF, 8'h00);
        check(moveAddr, 16'hFFFF);
    endtask
    task automatic t_split;
        sfr_wr(8'hB2, 8'h0F, 8'h0B);
        sfr_wr(8'hAA, 8'h00, 8'h0F);
        do_move(1'b0, 1'b0, 8'hFF, 8'h00);
        check(moveOnChip, 1'b1);
        sfr_wr(8'hAA, 8'h00, 8'h10);
        do_move(1'b0, 1'b0, 8'h00, 8'h00);
        check(moveOnChip, 1'b0);
        check(lastAddr, 16'h1000);
        check(moveRdData, 8'h10);
        // Split without bank: high byte from latch
        sfr_wr(8'hB2, 8'h0F, 8'h07);
        do_move(1'b0, 1'b0, 8'h56, 8'h00);
        check(moveAddr, 16'hFF56);
        check(moveOnChip, 1'b0);
        check(lastAddr, 16'hFF56);
        check(moveRdData, 8'hA9);
    endtask
    task automatic t_mux;
        sfr_wr(8'hB2, 8'h0F, 8'h0F);
        sfr_wr(8'hAA, 8'h00, 8'h12);
        do_move(1'b0, 1'b0, 8'h34, 8'h00);
        check(moveAddr, 16'h1234);
        check(lastAddr, 16'h1234);
        check(moveRdData, 8'h26);
        sfr_wr(8'h83, 8'h00, 8'hC3);
        sfr_wr(8'h82, 8'h00, 8'hA5);
        do_move(1'b1, 1'b1, 8'h00, 8'h5A);
        check(lastAddr, 16'hC3A5);
        check(lastWrData, 8'h5A);
    endtask
    task automatic t_nonmux;
        nonMux <= 1'b1;
        sfr_wr(8'hB2, 8'h0F, 8'h1F);
        sfr_wr(8'h83, 8'h00, 8'hBE);
        sfr_wr(8'h82, 8'h00, 8'hEF);
        do_move(1'b0, 1'b1, 8'h00, 8'h00);
        check(lastAddr, 16'hBEEF);
        check(moveRdData, 8'h51);
        do_move(1'b1, 1'b1, 8'h00, 8'h3C);
        check(lastWrData, 8'h3C);
    endtask
    task automatic close_out;
        $display("Counts: %0d checks, %0d mismatches", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_onchip;
        t_split;
        t_mux;
        t_nonmux;
        close_out;
    end
    // Whole run needs under a hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        close_out;
    end
endmodule
bind emi_external_mem_port emi_port_asserts u_chk (.*);
